// file: design/gpt_pkg.sv
// constants, register map and field layout of the general purpose timer set
package gpt_pkg;
    // timer slots
    localparam int NUM_TIMERS = 5;
    localparam int TMR_SA     = 0;
    localparam int TMR_A_LO   = 1;
    localparam int TMR_A_HI   = 2;
    localparam int TMR_B_LO   = 3;
    localparam int TMR_B_HI   = 4;
    // byte address: [6:4] timer slot, [3:2] register in slot
    localparam int       ADDR_W      = 7;
    localparam int       SLOT_MSB    = 6;
    localparam int       SLOT_LSB    = 4;
    localparam int       SEL_MSB     = 3;
    localparam int       SEL_LSB     = 2;
    localparam logic [1:0] REG_CTRL   = 2'h0;
    localparam logic [1:0] REG_COUNT  = 2'h1;
    localparam logic [1:0] REG_PERIOD = 2'h2;
    localparam logic [1:0] REG_HOLD   = 2'h3;
    // control fields
    localparam int BIT_RUN     = 15;
    localparam int BIT_IDLE    = 13;
    localparam int BIT_GATE    = 6;
    localparam int PS_MSB      = 5;
    localparam int PS_LSB      = 4;
    localparam int BIT_CASCADE = 3;
    localparam int BIT_SYNC    = 2;
    localparam int BIT_SRC     = 1;
    localparam logic [15:0] CTRL_MASK_SA = 16'ha076;
    localparam logic [15:0] CTRL_MASK_LO = 16'ha07a;
    localparam logic [15:0] CTRL_MASK_HI = 16'ha072;
    localparam logic [15:0] CTRL_RESET   = 16'h0000;
    localparam logic [15:0] COUNT_RESET  = 16'h0000;
    localparam logic [15:0] PERIOD_RESET = 16'hffff;
    // prescale codes and terminal counts
    localparam logic [1:0] PS_DIV1   = 2'h0;
    localparam logic [1:0] PS_DIV8   = 2'h1;
    localparam logic [1:0] PS_DIV64  = 2'h2;
    localparam logic [1:0] PS_DIV256 = 2'h3;
    localparam logic [7:0] PS_LIM1   = 8'h00;
    localparam logic [7:0] PS_LIM8   = 8'h07;
    localparam logic [7:0] PS_LIM64  = 8'h3f;
    localparam logic [7:0] PS_LIM256 = 8'hff;
    // instruction clock is the oscillator divided by two
    localparam int TCY_DIV = 2;
endpackage

// file: design/gpt_tick_if.sv
// control fields and count ticks passed between the top and one tick generator
`timescale 1ns/1ps
interface gpt_tick_if;
    logic       run;        // run enable
    logic       idle_halt;  // stop while idle
    logic       gate_en;    // gated accumulate
    logic [1:0] prescale;   // prescale select
    logic       sync_sel;   // synchronise external clock
    logic       src_ext;    // external clock source
    logic       ctrl_write; // control written while running
    logic       tick;       // prescaled count pulse
    logic       gate_fall;  // gate falling edge event
    modport top  (output run, idle_halt, gate_en, prescale, sync_sel, src_ext, ctrl_write,
                  input tick, gate_fall);
    modport core (input run, idle_halt, gate_en, prescale, sync_sel, src_ext, ctrl_write,
                  output tick, gate_fall);
endinterface

// file: design/gpt_tick_gen.sv
// clock select, sync, gate and prescaler of one timer
`timescale 1ns/1ps
module gpt_tick_gen
    import gpt_pkg::*;
#(
    parameter bit HAS_ASYNC = 1'b1        // raw external clock allowed
) (
    input  wire logic clk,                // system clock
    input  wire logic rst,                // async reset, high
    input  wire logic tcy_en,             // instruction clock enable
    input  wire logic idle_mode,          // device in idle
    input  wire logic ext_pin,            // external clock or gate pin
    gpt_tick_if.core  tif                 // controls and ticks
);
    logic       ext_s1;
    logic       ext_s2;
    logic       ext_raw;
    logic       ext_prev;
    logic       gate_prev;
    logic [7:0] pcnt;
    logic [7:0] next_pcnt;
    logic [7:0] limit;
    logic       ext_level;
    logic       active;
    logic       gated;
    logic       src_tick;
    logic       at_limit;

    // pin sampling, edge history and prescale counter
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ext_s1    <= 1'b0;
            ext_s2    <= 1'b0;
            ext_raw   <= 1'b0;
            ext_prev  <= 1'b0;
            gate_prev <= 1'b0;
            pcnt      <= 8'h00;
        end else begin
            ext_s1    <= ext_pin;
            ext_s2    <= ext_s1;
            ext_raw   <= ext_pin;
            ext_prev  <= ext_level;
            gate_prev <= ext_s2;
            pcnt      <= next_pcnt;
        end
    end

    // source choice, gating and division
    always_comb begin
        unique case (tif.prescale)
            PS_DIV1:   limit = PS_LIM1;
            PS_DIV8:   limit = PS_LIM8;
            PS_DIV64:  limit = PS_LIM64;
            PS_DIV256: limit = PS_LIM256;
        endcase
        ext_level = (tif.sync_sel || !HAS_ASYNC) ? ext_s2 : ext_raw;
        active    = tif.run && !(tif.idle_halt && idle_mode);
        gated     = tif.gate_en && !tif.src_ext;
        src_tick  = active && (tif.src_ext ? (ext_level && !ext_prev)
                                           : (tcy_en && (!gated || ext_s2)));
        at_limit  = (pcnt == limit);
        next_pcnt = pcnt;
        if (!tif.run || tif.ctrl_write) begin
            next_pcnt = 8'h00;
        end else if (src_tick) begin
            next_pcnt = at_limit ? 8'h00 : pcnt + 8'h01;
        end
    end

    assign tif.tick      = src_tick && at_limit && !tif.ctrl_write;
    assign tif.gate_fall = active && gated && gate_prev && !ext_s2;
endmodule

// file: design/gpt_top.sv
// general purpose timer set with avalon-mm register slave
//
// Implementation choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
module gpt_top
    import gpt_pkg::*;
(
    input  wire logic              clk,                       // system clock, oscillator rate
    input  wire logic              rst,                       // async reset, high
    input  wire logic [ADDR_W-1:0] avs_address,               // byte address
    input  wire logic              avs_read,                  // read request
    input  wire logic              avs_write,                 // write request
    input  wire logic [31:0]       avs_writedata,             // write data
    input  wire logic [3:0]        avs_byteenable,            // byte lanes
    output logic      [31:0]       avs_readdata,              // read data
    output logic                   avs_waitrequest,           // stall
    input  wire logic              idle_mode,                 // device in idle mode
    input  wire logic              standalone_ext_clock_pin,  // standalone clock or gate pin
    input  wire logic [3:0]        pair_ext_clock_pin,        // a low, a high, b low, b high
    output logic                   standalone_irq_flag,       // standalone event pulse
    output logic                   pair_a_low_irq_flag,       // pair a low 16-bit event pulse
    output logic                   pair_a_irq_flag,           // pair a high or 32-bit event pulse
    output logic                   pair_b_low_irq_flag,       // pair b low 16-bit event pulse
    output logic                   pair_b_irq_flag,           // pair b high or 32-bit event pulse
    output logic                   conv_trigger               // conversion start pulse
);
    logic [15:0]           ctrl      [NUM_TIMERS];
    logic [15:0]           cnt       [NUM_TIMERS];
    logic [15:0]           per       [NUM_TIMERS];
    logic [15:0]           hold      [NUM_TIMERS];
    logic [15:0]           next_ctrl [NUM_TIMERS];
    logic [15:0]           next_cnt  [NUM_TIMERS];
    logic [15:0]           next_per  [NUM_TIMERS];
    logic [15:0]           next_hold [NUM_TIMERS];
    logic [NUM_TIMERS-1:0] flag;
    logic [NUM_TIMERS-1:0] next_flag;
    logic [NUM_TIMERS-1:0] match;
    logic [NUM_TIMERS-1:0] fall;
    logic [NUM_TIMERS-1:0] tick;
    logic [NUM_TIMERS-1:0] gate_fall;
    logic [NUM_TIMERS-1:0] pins;
    logic [NUM_TIMERS-1:0] ctrl_wr;
    logic                  conv;
    logic                  next_conv;
    logic                  next_wait;
    logic [31:0]           next_rdata;
    logic                  tcy_cnt;
    logic                  next_tcy_cnt;
    logic                  tcy_en;
    logic                  req;
    logic                  commit_wr;
    logic [2:0]            slot;
    logic [1:0]            sel;
    logic                  slot_ok;
    logic [31:0]           rd_mux;
    logic [31:0]           sum32;

    gpt_tick_if tif [NUM_TIMERS] ();

    assign pins = {pair_ext_clock_pin, standalone_ext_clock_pin};

    // control mask of one slot: unimplemented bits read zero and ignore writes
    function automatic logic [15:0] ctrl_mask(input int i);
        logic [15:0] m;
        m = CTRL_MASK_HI;
        if (i == TMR_SA) begin
            m = CTRL_MASK_SA;
        end else if (i == TMR_A_LO || i == TMR_B_LO) begin
            m = CTRL_MASK_LO;
        end
        return m;
    endfunction

    // byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
        logic [15:0] r;
        r = old;
        if (be[0]) begin
            r[7:0] = wd[7:0];
        end
        if (be[1]) begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction

    // per-slot effective controls and tick generators
    for (genvar g = 0; g < NUM_TIMERS; g++) begin : g_tmr
        logic casc_hi;
        if (g == TMR_A_HI || g == TMR_B_HI) begin : g_hi
            assign casc_hi = ctrl[g-1][BIT_CASCADE];
        end else begin : g_nohi
            assign casc_hi = 1'b0;
        end
        assign tif[g].run        = ctrl[g][BIT_RUN] && !casc_hi;
        assign tif[g].idle_halt  = ctrl[g][BIT_IDLE];
        assign tif[g].gate_en    = ctrl[g][BIT_GATE];
        assign tif[g].prescale   = ctrl[g][PS_MSB:PS_LSB];
        assign tif[g].sync_sel   = (g == TMR_SA) ? ctrl[g][BIT_SYNC] : 1'b1;
        assign tif[g].src_ext    = ctrl[g][BIT_SRC];
        assign tif[g].ctrl_write = ctrl_wr[g];
        assign tick[g]           = tif[g].tick;
        assign gate_fall[g]      = tif[g].gate_fall;
        gpt_tick_gen #(
            .HAS_ASYNC (g == TMR_SA)
        ) u_tick (
            .clk       (clk),
            .rst       (rst),
            .tcy_en    (tcy_en),
            .idle_mode (idle_mode),
            .ext_pin   (pins[g]),
            .tif       (tif[g])
        );
    end

    // instruction clock enable, one pulse every two oscillator cycles
    always_comb begin
        next_tcy_cnt = tcy_cnt + 1'b1;
        tcy_en       = (TCY_DIV == 2) && tcy_cnt;
    end

    // bus handshake and read mux
    always_comb begin
        slot      = avs_address[SLOT_MSB:SLOT_LSB];
        sel       = avs_address[SEL_MSB:SEL_LSB];
        slot_ok   = (int'(slot) < NUM_TIMERS);
        req       = (avs_read || avs_write) && avs_waitrequest;
        commit_wr = avs_write && !avs_waitrequest;
        next_wait = !req;
        rd_mux    = 32'h0000_0000;
        if (slot_ok) begin
            unique case (sel)
                REG_CTRL:   rd_mux[15:0] = ctrl[slot] & ctrl_mask(int'(slot));
                REG_COUNT:  rd_mux[15:0] = cnt[slot];
                REG_PERIOD: rd_mux[15:0] = per[slot];
                REG_HOLD:   rd_mux[15:0] = hold[slot];
            endcase
        end
        next_rdata = (req && avs_read) ? rd_mux : avs_readdata;
        for (int i = 0; i < NUM_TIMERS; i++) begin
            ctrl_wr[i] = commit_wr && slot_ok && (int'(slot) == i) && (sel == REG_CTRL)
                         && ctrl[i][BIT_RUN];
        end
    end

    // counting, matches, cascading and register writes
    always_comb begin
        match = '0;
        fall  = gate_fall;
        sum32 = 32'h0000_0000;
        for (int i = 0; i < NUM_TIMERS; i++) begin
            next_ctrl[i] = ctrl[i];
            next_cnt[i]  = cnt[i];
            next_per[i]  = per[i];
            next_hold[i] = hold[i];
            if (tick[i]) begin
                if (cnt[i] == per[i]) begin
                    next_cnt[i] = COUNT_RESET;
                    match[i]    = 1'b1;
                end else begin
                    next_cnt[i] = cnt[i] + 16'h0001;
                end
            end
        end
        // cascaded pairs: low slot controls, high slot holds the upper word
        for (int p = TMR_A_LO; p <= TMR_B_LO; p += 2) begin
            if (ctrl[p][BIT_CASCADE]) begin
                match[p]      = 1'b0;
                match[p+1]    = 1'b0;
                fall[p+1]     = gate_fall[p];
                fall[p]       = 1'b0;
                next_cnt[p+1] = cnt[p+1];
                sum32         = {cnt[p+1], cnt[p]} + 32'h0000_0001;
                if (tick[p]) begin
                    if ({cnt[p+1], cnt[p]} == {per[p+1], per[p]}) begin
                        next_cnt[p]   = COUNT_RESET;
                        next_cnt[p+1] = COUNT_RESET;
                        match[p+1]    = 1'b1;
                    end else begin
                        next_cnt[p]   = sum32[15:0];
                        next_cnt[p+1] = sum32[31:16];
                    end
                end
                if (req && avs_read && slot_ok && int'(slot) == p && sel == REG_COUNT) begin
                    next_hold[p+1] = cnt[p+1];
                end
            end
        end
        next_flag = match | fall;
        next_conv = match[TMR_A_HI];
        // software writes win over counting in the same cycle
        if (commit_wr && slot_ok) begin
            unique case (sel)
                REG_CTRL:   next_ctrl[slot] = merge16(ctrl[slot], avs_writedata, avs_byteenable)
                                              & ctrl_mask(int'(slot));
                REG_COUNT:  next_cnt[slot]  = merge16(cnt[slot], avs_writedata, avs_byteenable);
                REG_PERIOD: next_per[slot]  = merge16(per[slot], avs_writedata, avs_byteenable);
                REG_HOLD:   next_hold[slot] = hold[slot];
            endcase
        end
    end

    // register all state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_TIMERS; i++) begin
                ctrl[i] <= CTRL_RESET;
                cnt[i]  <= COUNT_RESET;
                per[i]  <= PERIOD_RESET;
                hold[i] <= COUNT_RESET;
            end
            flag            <= '0;
            conv            <= 1'b0;
            tcy_cnt         <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else begin
            for (int i = 0; i < NUM_TIMERS; i++) begin
                ctrl[i] <= next_ctrl[i];
                cnt[i]  <= next_cnt[i];
                per[i]  <= next_per[i];
                hold[i] <= next_hold[i];
            end
            flag            <= next_flag;
            conv            <= next_conv;
            tcy_cnt         <= next_tcy_cnt;
            avs_waitrequest <= next_wait;
            avs_readdata    <= next_rdata;
        end
    end

    // event outputs straight from flag flops, conversion trigger from the conv flop
    assign standalone_irq_flag = flag[TMR_SA];
    assign pair_a_low_irq_flag = flag[TMR_A_LO];
    assign pair_a_irq_flag     = flag[TMR_A_HI];
    assign pair_b_low_irq_flag = flag[TMR_B_LO];
    assign pair_b_irq_flag     = flag[TMR_B_HI];
    assign conv_trigger        = conv;
endmodule

// file: tb/gpt_properties.sv
// concurrent checks on the timer set register bus and event outputs
`timescale 1ns/1ps
module gpt_properties
    import gpt_pkg::*;
(
    input wire logic              clk,                 // system clock
    input wire logic              rst,                 // async reset, high
    input wire logic [ADDR_W-1:0] avs_address,         // byte address
    input wire logic              avs_read,            // read request
    input wire logic              avs_write,           // write request
    input wire logic [31:0]       avs_readdata,        // read data
    input wire logic              avs_waitrequest,     // stall
    input wire logic              standalone_irq_flag, // standalone event
    input wire logic              pair_a_irq_flag,     // pair a event
    input wire logic              pair_b_irq_flag,     // pair b event
    input wire logic              conv_trigger         // conversion start
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // bus handshake: one wait cycle, one answer cycle, never unasked
    wait_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer late");
    wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    wait_cause_a: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
        else $error("answer without request");
    // read data: upper half, unmapped slots and reserved standalone control bits read zero
    upper_zero_a: assert property (!avs_waitrequest && avs_read |-> avs_readdata[31:16] == 16'h0000)
        else $error("upper read half not zero");
    unmapped_zero_a: assert property (!avs_waitrequest && avs_read && avs_address[SLOT_MSB:SLOT_LSB] > 3'h4
        |-> avs_readdata == 32'h0000_0000) else $error("unmapped read not zero");
    ctrl_mask_a: assert property (!avs_waitrequest && avs_read && avs_address == 7'h00
        |-> (avs_readdata[15:0] & ~CTRL_MASK_SA) == 16'h0000) else $error("reserved control bit set");
    // events: trigger only with the pair a event, standalone one-cycle pulses, quiet after reset
    conv_cause_a: assert property (conv_trigger |-> pair_a_irq_flag)
        else $error("trigger without pair a event");
    sa_pulse_a: assert property (standalone_irq_flag |=> !standalone_irq_flag)
        else $error("standalone flag longer than one cycle");
    reset_quiet_a: assert property ($fell(rst) |-> avs_waitrequest && !conv_trigger && !pair_b_irq_flag)
        else $error("outputs active after reset");
    // main scenarios reached
    cover property (conv_trigger);
    cover property (pair_b_irq_flag);
    cover property (avs_read && !avs_waitrequest && avs_address[SLOT_MSB:SLOT_LSB] > 3'h4);
endmodule

// file: tb/tb_gpt_top.sv
// self-checking bench for the general purpose timer set
`timescale 1ns/1ps
module tb_gpt_top
    import gpt_pkg::*;
;
    localparam logic [15:0] C_RUN = 16'h8000, C_IDLE = 16'h2000, C_GATE = 16'h0040;
    localparam logic [15:0] C_CAS = 16'h0008, C_SYNC = 16'h0004, C_SRC  = 16'h0002;
    logic              clk, rst, avs_read, avs_write, idle_mode, sa_pin, tog_en, avs_waitrequest;
    logic [ADDR_W-1:0] avs_address;
    logic [31:0]       avs_writedata, avs_readdata;
    logic [3:0]        pair_pin;
    logic [5:0]        flg;
    logic [15:0]       exp_q [$];
    int                error_cnt, n_tests, ph, p, k;
    int                fcnt [6];
    int                dv [4] = '{1, 8, 64, 256};

    gpt_top dut_u (
        .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .idle_mode(idle_mode), .standalone_ext_clock_pin(sa_pin),
        .pair_ext_clock_pin(pair_pin), .standalone_irq_flag(flg[0]), .pair_a_low_irq_flag(flg[1]),
        .pair_a_irq_flag(flg[3]), .pair_b_low_irq_flag(flg[2]), .pair_b_irq_flag(flg[4]),
        .conv_trigger(flg[5]));

    // 100 mhz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic tally_and_finish();
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // one avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [15:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= {16'h0000, d};
        avs_write <= wr;
        avs_read <= ~wr;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        chk("bus_answer", 1, n < 50);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input int s, input int r, input logic [15:0] e);
        exp_q.push_back(e);
        bus(1'b0, ADDR_W'(s * 16 + r * 4), 16'h0000);
    endtask

    task automatic wr(input int s, input int r, input logic [15:0] d);
        bus(1'b1, ADDR_W'(s * 16 + r * 4), d);
    endtask

    task automatic wt(input int c);
        repeat (c) @(posedge clk);
    endtask

    task automatic clr();
        wt(2);
        foreach (fcnt[i]) fcnt[i] = 0;
    endtask

    // cycles between two consecutive pulses of one event output
    task automatic gap(input int i, input int e);
        int n;
        n = 0;
        while (flg[i] !== 1'b1 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (flg[i] !== 1'b1 && n < 3000);
        chk("flag_gap", e, n);
    endtask

    // read results compared with the oldest note
    always @(posedge clk) begin
        if (!rst && avs_read && avs_waitrequest === 1'b0) begin
            chk("readdata", {16'h0000, exp_q.pop_front()}, avs_readdata);
        end
    end

    // event pulse counters
    always @(posedge clk) begin
        foreach (fcnt[i]) fcnt[i] += (flg[i] === 1'b1);
    end

    // external clock pins toggle every three cycles
    always @(posedge clk) begin
        if (tog_en) begin
            ph <= (ph == 2) ? 0 : ph + 1;
            if (ph == 2) begin
                sa_pin <= ~sa_pin;
                pair_pin <= ~pair_pin;
            end
        end
    end

    // watchdog
    initial begin
        wt(40000);
        error_cnt++;
        tally_and_finish();
    end

    // main sequence
    initial begin
        void'($urandom(32'h5e7f));
        {rst, avs_read, avs_write, idle_mode, sa_pin, tog_en} = 6'b100000;
        {avs_address, avs_writedata, pair_pin} = '0;
        {error_cnt, n_tests, ph} = '0;
        wt(2);
        rst <= 1'b0;
        wt(1);
        rd(0, 0, 16'h0000);
        rd(0, 2, 16'hffff);
        wr(0, 0, 16'h7fff);
        rd(0, 0, 16'h2076);
        wr(6, 0, 16'h1234);
        rd(6, 0, 16'h0000);
        wr(0, 0, 16'h0000);
        wr(0, 2, 16'h0001);
        for (int i = 0; i < 4; i++) begin
            wr(0, 0, C_RUN | 16'(i << 4));
            gap(0, TCY_DIV * dv[i] * 2);
        end
        wr(0, 0, 16'h0000);
        wr(0, 1, 16'h0005);
        clr();
        wt(40);
        rd(0, 1, 16'h0005);
        chk("stopped_flags", 0, fcnt[0]);
        wr(0, 1, 16'h0000);
        wr(0, 2, 16'h0000);
        wr(0, 0, C_RUN | 16'h0010);
        clr();
        repeat (10) wr(0, 0, C_RUN | 16'h0010);
        chk("rewrite_flags", 0, fcnt[0]);
        gap(0, TCY_DIV * 8);
        idle_mode <= 1'b1;
        wr(0, 0, C_RUN | C_IDLE);
        clr();
        wt(20);
        chk("idle_flags", 0, fcnt[0]);
        wr(0, 0, C_RUN);
        gap(0, TCY_DIV);
        idle_mode <= 1'b0;
        sa_pin <= 1'b0;
        wr(0, 0, C_RUN | C_GATE);
        clr();
        wt(30);
        chk("gate_low_flags", 0, fcnt[0]);
        sa_pin <= 1'b1;
        gap(0, TCY_DIV);
        wr(0, 2, 16'hffff);
        clr();
        sa_pin <= 1'b0;
        wt(10);
        chk("gate_fall_flags", 1, fcnt[0]);
        wr(0, 2, 16'h0002);
        wr(0, 1, 16'h0000);
        wr(3, 2, 16'h0002);
        tog_en <= 1'b1;
        wr(0, 0, C_RUN | C_SRC);
        gap(0, 6 * 3);
        wr(0, 0, C_RUN | C_SRC | C_SYNC);
        gap(0, 6 * 3);
        wr(3, 0, C_RUN | C_SRC | C_GATE);
        gap(2, 6 * 3);
        tog_en <= 1'b0;
        wr(0, 0, 16'h0000);
        wr(3, 0, 16'h0000);
        p = $urandom_range(7, 0);
        k = $urandom_range(2, 0);
        wr(1, 2, 16'(p));
        wr(1, 0, C_RUN | 16'(k << 4));
        gap(1, TCY_DIV * dv[k] * (p + 1));
        wr(1, 0, 16'h0000);
        wr(2, 2, 16'h0001);
        wr(2, 0, C_RUN);
        gap(5, TCY_DIV * 2);
        wr(2, 0, 16'h0000);
        wr(4, 2, 16'h0000);
        wr(4, 0, C_RUN);
        clr();
        wt(20);
        chk("b_flags", 1, fcnt[4] > 0);
        chk("b_conv", 0, fcnt[5]);
        wr(4, 0, 16'h0000);
        wr(1, 0, C_CAS);
        wr(2, 1, 16'h0001);
        wr(1, 1, 16'h0005);
        rd(1, 1, 16'h0005);
        rd(2, 3, 16'h0001);
        wr(2, 2, 16'h0002);
        wr(1, 2, 16'h0007);
        wr(2, 0, C_RUN);
        wr(1, 0, C_CAS | C_RUN);
        clr();
        wt(40);
        chk("no_match_32", 0, fcnt[3]);
        wr(1, 0, C_CAS);
        wr(1, 1, 16'h0005);
        wr(2, 2, 16'h0001);
        clr();
        wr(1, 0, C_CAS | C_RUN);
        wt(30);
        chk("match_32", 1, fcnt[3]);
        chk("conv_32", 1, fcnt[5]);
        chk("low_quiet", 0, fcnt[1]);
        tally_and_finish();
    end
endmodule

bind gpt_top gpt_properties chk_u (
    .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .standalone_irq_flag(standalone_irq_flag),
    .pair_a_irq_flag(pair_a_irq_flag), .pair_b_irq_flag(pair_b_irq_flag), .conv_trigger(conv_trigger));
